// ==== design/ccrb_top.sv ====
`timescale 1ns/100ps
// What this block does
// [R01] Signed upper heat limit, reset 18130; charge cap slopes 31 down to 0.
// [R02] Signed lower heat limit, reset 17897; thermal capping starts here.
// [R03] Configuration bit 5 halts battery charging; host sets it with care.
// [R04] Config bit 4 measures series resistance, now or at next charge.
// [R05] Config bit 3 forces fast telemetry; clear allows slow rate idle.
// [R06] Config bit 2 keeps telemetry running always, even on battery only.
// [R07] Config bit 1 enables power-point tracking of the undervoltage code.
// [R08] Hold 6-bit input current cap code, reset 63.
// [R09] Input current limit only cuts charge current, never the load path.
// [R10] Hold 8-bit input droop code, reset 31; droop reduces charge current.
// [R11] Tracker code overrides written code while on; active code readable.
// [R12] Writing key 21325 to storage mode register arms it; resets to zero.
// [R13] Armed storage mode enters once input supply is below about 1V.
// [R14] Charge code follows setting unless thermal or algorithm override.
// [R15] Registers are 16-bit words by command code; unused bits read zero.
module ccrb_top
  import ccrb_pkg::*;
#(
  parameter int TEL_FAST_CYCLES = TEL_FAST_CYC,
  parameter int TEL_SLOW_CYCLES = TEL_SLOW_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic        i_wr_word,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_rd_word,
  output logic             o_rd_valid,
  output logic      [15:0] o_rd_data,
  input  wire logic [15:0] i_die_temp,
  input  wire logic [4:0]  i_charge_current_setting,
  input  wire logic        i_temp_algo_active,
  input  wire logic [4:0]  i_temp_algo_code,
  input  wire logic        i_charge_running,
  input  wire logic        i_charge_start,
  input  wire logic [15:0] i_input_power,
  input  wire logic        i_input_present,
  input  wire logic        i_iin_over_pin,
  input  wire logic        i_vin_droop_pin,
  input  wire logic        i_vin_below_1v_pin,
  output logic      [4:0]  o_charge_current_code,
  output logic             o_thermal_reg_active,
  output logic             o_charge_suspend,
  output logic             o_bsr_start,
  output logic             o_telemetry_on,
  output logic             o_telemetry_tick,
  output logic      [5:0]  o_input_current_cap_code,
  output logic             o_iin_limit_active,
  output logic      [7:0]  o_uv_code_active,
  output logic             o_uv_limit_active,
  output logic             o_storage_armed,
  output logic             o_storage_enter
);

  if (TEL_FAST_CYCLES < 2 ||
      TEL_SLOW_CYCLES < TEL_FAST_CYCLES) begin : g_bad_tel
    $error("telemetry periods out of range");
  end

  // ==========================================================
  // Registers
  logic [15:0] heat_limit_start_point;
  logic [15:0] heat_limit_stop_point;
  logic [5:0]  system_configuration;
  logic [5:0]  input_current_cap_code;
  logic [7:0]  supply_droop_threshold_code;
  logic [15:0] storage_mode_key;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      heat_limit_start_point      <= RST_HEAT_START;
      heat_limit_stop_point       <= RST_HEAT_STOP;
      system_configuration        <= RST_SYS_CFG;
      input_current_cap_code      <= RST_IIN_CAP;
      supply_droop_threshold_code <= RST_UV_CODE;
      storage_mode_key            <= RST_STORE_KEY;
    end else if (i_wr_word) begin
      case (i_cmd_code)
        CMD_HEAT_START: heat_limit_start_point <= i_wr_data;   // [R02]
        CMD_HEAT_STOP:  heat_limit_stop_point  <= i_wr_data;   // [R01]
        CMD_SYS_CFG:
          system_configuration <= i_wr_data[5:0] & CFG_WR_MASK; // [R15]
        CMD_IIN_CAP:    input_current_cap_code <= i_wr_data[5:0]; // [R08]
        CMD_UV_CODE:
          supply_droop_threshold_code <= i_wr_data[7:0];        // [R10]
        CMD_STORE_KEY:  storage_mode_key <= i_wr_data;          // [R12]
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Read port
  logic [7:0] uv_code_track;
  logic       mppt_en;

  assign mppt_en          = system_configuration[CFG_MPPT_EN];
  assign o_uv_code_active = mppt_en ? uv_code_track
                                    : supply_droop_threshold_code; // [R11]

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= 16'h0000;
    end else begin
      o_rd_valid <= i_rd_word;
      if (i_rd_word) begin
        case (i_cmd_code)                                       // [R15]
          CMD_HEAT_START: o_rd_data <= heat_limit_start_point;
          CMD_HEAT_STOP:  o_rd_data <= heat_limit_stop_point;
          CMD_SYS_CFG:    o_rd_data <= {10'h000, system_configuration};
          CMD_IIN_CAP:    o_rd_data <= {10'h000, input_current_cap_code};
          CMD_UV_CODE:
            o_rd_data <= {8'h00, supply_droop_threshold_code};
          CMD_STORE_KEY:  o_rd_data <= storage_mode_key;
          CMD_UV_ACTIVE:  o_rd_data <= {8'h00, o_uv_code_active}; // [R11]
          default:        o_rd_data <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Pin synchronisers
  // Analog comparators are asynchronous; a change counts once
  // the second and third stages agree.
  localparam int NPIN = 3;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin_q;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_q  <= '0;
    end else begin
      pin_s1 <= {i_vin_below_1v_pin, i_vin_droop_pin, i_iin_over_pin};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int k = 0; k < NPIN; k++) begin
        if (pin_s2[k] == pin_s3[k]) begin
          pin_q[k] <= pin_s3[k];
        end
      end
    end
  end

  // ==========================================================
  // Charge current code
  function automatic logic [4:0] heat_cap(input logic [15:0] temp,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic signed [23:0] t;
    logic signed [23:0] l;
    logic signed [23:0] h;
    logic signed [23:0] q;
    t = 24'(signed'(temp));
    l = 24'(signed'(lo));
    h = 24'(signed'(hi));
    q = 24'sd0;
    if (t >= h) begin
      heat_cap = 5'h00;
    end else if (t <= l) begin
      heat_cap = CODE_FULL;
    end else begin
      q = ((h - t) * 24'sd31) / (h - l);
      heat_cap = q[4:0];
    end
  endfunction

  logic [4:0] thermal_cap;
  logic [4:0] base_code;
  logic       input_loop_cut;

  assign thermal_cap = heat_cap(i_die_temp, heat_limit_start_point,
                                heat_limit_stop_point);        // [R01] [R02]
  assign base_code   = i_temp_algo_active ? i_temp_algo_code
                                          : i_charge_current_setting; // [R14]
  // Input loops act on charge current only; load path is untouched
  assign input_loop_cut = o_iin_limit_active | o_uv_limit_active; // [R09]

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_charge_current_code <= 5'h00;
      o_thermal_reg_active  <= 1'b0;
    end else begin
      o_thermal_reg_active <= thermal_cap < base_code;           // [R01]
      if (input_loop_cut || o_charge_suspend) begin              // [R09]
        o_charge_current_code <= 5'h00;
      end else if (thermal_cap < base_code) begin
        o_charge_current_code <= thermal_cap;                    // [R01]
      end else begin
        o_charge_current_code <= base_code;                      // [R14]
      end
    end
  end

  assign o_charge_suspend         = system_configuration[CFG_SUSPEND]; // [R03]
  assign o_input_current_cap_code = input_current_cap_code;     // [R08]
  assign o_iin_limit_active       = pin_q[0];                   // [R09]
  assign o_uv_limit_active        = pin_q[1];                   // [R10]

  // ==========================================================
  // Series-resistance measurement
  logic bsr_pending;
  logic bsr_bit_d;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bsr_pending <= 1'b0;
      bsr_bit_d   <= 1'b0;
      o_bsr_start <= 1'b0;
    end else begin
      bsr_bit_d   <= system_configuration[CFG_RUN_BSR];
      o_bsr_start <= 1'b0;
      if (bsr_pending && (i_charge_running || i_charge_start)) begin
        o_bsr_start <= 1'b1;                                     // [R04]
        bsr_pending <= 1'b0;
      end
      // A new request in the same cycle wins over the clear
      if (system_configuration[CFG_RUN_BSR] && !bsr_bit_d) begin
        bsr_pending <= 1'b1;                                     // [R04]
      end
    end
  end

  // ==========================================================
  // Telemetry pacing
  logic        tel_fast;
  logic [31:0] tel_count;
  logic [31:0] tel_period;

  assign o_telemetry_on = system_configuration[CFG_FORCE_TEL]
                        | i_input_present | i_charge_running;    // [R06]
  assign tel_fast   = system_configuration[CFG_TEL_FAST]
                    | i_charge_running;                          // [R05]
  assign tel_period = tel_fast ? 32'(TEL_FAST_CYCLES)
                               : 32'(TEL_SLOW_CYCLES);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tel_count        <= 32'h0000_0000;
      o_telemetry_tick <= 1'b0;
    end else begin
      o_telemetry_tick <= 1'b0;
      if (!o_telemetry_on) begin
        tel_count <= 32'h0000_0000;
      end else if (tel_count >= tel_period - 32'h0000_0001) begin
        tel_count        <= 32'h0000_0000;
        o_telemetry_tick <= 1'b1;                                // [R05]
      end else begin
        tel_count <= tel_count + 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // Power-point tracker: perturb and observe, one step per
  // telemetry sample. Starts from the written code when enabled.
  logic        mppt_d;
  logic        track_up;
  logic [15:0] last_power;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mppt_d        <= 1'b0;
      track_up      <= 1'b1;
      last_power    <= 16'h0000;
      uv_code_track <= RST_UV_CODE;
    end else begin
      mppt_d <= mppt_en;
      if (mppt_en && !mppt_d) begin
        uv_code_track <= supply_droop_threshold_code;
        last_power    <= 16'h0000;
        track_up      <= 1'b1;
      end else if (mppt_en && o_telemetry_tick) begin            // [R07]
        last_power <= i_input_power;
        if ((i_input_power < last_power) ^ track_up) begin
          track_up <= 1'b1;
          if (uv_code_track != 8'hff) begin
            uv_code_track <= uv_code_track + 8'h01;
          end
        end else begin
          track_up <= 1'b0;
          if (uv_code_track != 8'h00) begin
            uv_code_track <= uv_code_track - 8'h01;
          end
        end
      end
    end
  end

  // ==========================================================
  // Storage mode
  assign o_storage_armed = storage_mode_key == STORE_ARM_KEY;  // [R12]

  // Latched: once entered, only reset leaves it
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_storage_enter <= 1'b0;
    end else if (o_storage_armed && pin_q[2]) begin
      o_storage_enter <= 1'b1;                                   // [R13]
    end
  end

endmodule

// ==== design/ccrb_pkg.sv ====
package ccrb_pkg;
  // Command codes
  localparam logic [7:0]  CMD_HEAT_START  = 8'h10;
  localparam logic [7:0]  CMD_HEAT_STOP   = 8'h11;
  localparam logic [7:0]  CMD_SYS_CFG     = 8'h14;
  localparam logic [7:0]  CMD_IIN_CAP     = 8'h15;
  localparam logic [7:0]  CMD_UV_CODE     = 8'h16;
  localparam logic [7:0]  CMD_STORE_KEY   = 8'h19;
  localparam logic [7:0]  CMD_UV_ACTIVE   = 8'h3f;
  // Reset values
  localparam logic [15:0] RST_HEAT_START  = 16'h45e9;
  localparam logic [15:0] RST_HEAT_STOP   = 16'h46d2;
  localparam logic [5:0]  RST_SYS_CFG     = 6'h00;
  localparam logic [5:0]  RST_IIN_CAP     = 6'h3f;
  localparam logic [7:0]  RST_UV_CODE     = 8'h1f;
  localparam logic [15:0] RST_STORE_KEY   = 16'h0000;
  localparam logic [15:0] STORE_ARM_KEY   = 16'h534d;
  // Configuration bit positions
  localparam int CFG_SUSPEND   = 5;
  localparam int CFG_RUN_BSR   = 4;
  localparam int CFG_TEL_FAST  = 3;
  localparam int CFG_FORCE_TEL = 2;
  localparam int CFG_MPPT_EN   = 1;
  localparam logic [5:0]  CFG_WR_MASK     = 6'h3e;
  // Charge code full scale
  localparam logic [4:0]  CODE_FULL       = 5'h1f;
  // Timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int TEL_FAST_MS   = 11;
  localparam int TEL_SLOW_S    = 5;
  localparam int TEL_FAST_CYC  = TEL_FAST_MS * (CLK_HZ / 1000);
  localparam int TEL_SLOW_CYC  = TEL_SLOW_S * CLK_HZ;
endpackage

// ==== tb/ccrb_properties.sv ====
`timescale 1ns/100ps
// ========================================
// Register port and output checks
module ccrb_properties
  import ccrb_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic [7:0]  i_cmd_code,
  input wire logic        i_wr_word,
  input wire logic [15:0] i_wr_data,
  input wire logic        i_rd_word,
  input wire logic        o_rd_valid,
  input wire logic [15:0] o_rd_data,
  input wire logic [4:0]  o_charge_current_code,
  input wire logic        o_charge_suspend,
  input wire logic        o_bsr_start,
  input wire logic [5:0]  o_input_current_cap_code,
  input wire logic        o_iin_limit_active,
  input wire logic        o_uv_limit_active,
  input wire logic        o_storage_armed,
  input wire logic        o_storage_enter
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  AST_RD_VALID: assert property (i_rd_word |=> o_rd_valid)
    else $error("read strobe gave no valid pulse");
  AST_UNMAPPED: assert property (i_rd_word && i_cmd_code == 8'h12
    |=> o_rd_data == 16'h0000) else $error("unmapped read not zero");
  AST_SUSP_CFG: assert property (i_wr_word && i_cmd_code ==
    CMD_SYS_CFG |=> o_charge_suspend == $past(i_wr_data[5]))
    else $error("suspend bit not taken");
  AST_SUSP_ZERO: assert property (o_charge_suspend
    |=> o_charge_current_code == 5'h00) else $error("charging not halted");
  AST_IIN_ZERO: assert property (o_iin_limit_active
    |=> o_charge_current_code == 5'h00) else $error("limit kept charging");
  AST_UV_ZERO: assert property (o_uv_limit_active
    |=> o_charge_current_code == 5'h00) else $error("droop kept charging");
  AST_CAP_WR: assert property (i_wr_word && i_cmd_code == CMD_IIN_CAP
    |=> o_input_current_cap_code == $past(i_wr_data[5:0]))
    else $error("cap code write lost");
  AST_ARM: assert property (i_wr_word && i_cmd_code == CMD_STORE_KEY
    |=> o_storage_armed == ($past(i_wr_data) == STORE_ARM_KEY))
    else $error("arming does not follow key");
  AST_ENTER_ARM: assert property ($rose(o_storage_enter)
    |-> $past(o_storage_armed)) else $error("entered while not armed");
  AST_BSR_ONE: assert property (o_bsr_start |=> !o_bsr_start)
    else $error("measurement start not one cycle");

  cover property (o_rd_valid);
  cover property (o_bsr_start);
  cover property (o_storage_enter);
  cover property (o_uv_limit_active);
endmodule

// ==== tb/ccrb_host_model.sv ====
`timescale 1ns/100ps
// ========================================
// Host on the register word port
module ccrb_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_rd_valid,
  input  wire logic [15:0] i_rd_data,
  output logic      [7:0]  o_cmd,
  output logic             o_wr,
  output logic      [15:0] o_wdata,
  output logic             o_rd
);
  initial begin
    o_cmd = 8'h00;
    o_wr = 1'b0;
    o_wdata = 16'h0000;
    o_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge i_clk);
    #1;
    o_cmd = c;
    o_wdata = d; // Key or cautious suspend set by caller
    o_wr = 1'b1; // One whole word per strobe
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    // Released lines must not keep the last value
    o_cmd = ~c;
    o_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] c, output logic [15:0] q);
    @(posedge i_clk);
    #1;
    o_cmd = c;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    o_cmd = ~c;
    q = i_rd_valid ? i_rd_data : 16'hxxxx;
  endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/100ps
// ========================================
// Bench
module tb
  import ccrb_pkg::*;
;
  logic        i_clk, i_sys_rst, wr, rd, bsr, tick, run, start, pres;
  logic        algo, iin_p, droop_p, low_p;
  logic [7:0]  cmd;
  logic [15:0] wd, temp, q, pwr;
  logic [4:0]  set, acode, code;
  logic        rdv, therm, susp, tel_on, iin_a, uv_a, armed, enter;
  logic [15:0] rdd;
  logic [5:0]  cap;
  logic [7:0]  uv;
  int          err_total, n_compared, cycles;

  ccrb_top #(.TEL_FAST_CYCLES(20), .TEL_SLOW_CYCLES(100)) ccrb_top_inst (
    .i_clk, .i_sys_rst, .i_cmd_code(cmd), .i_wr_word(wr), .i_wr_data(wd),
    .i_rd_word(rd), .o_rd_valid(rdv), .o_rd_data(rdd), .i_die_temp(temp),
    .i_charge_current_setting(set), .i_temp_algo_active(algo),
    .i_temp_algo_code(acode), .i_charge_running(run),
    .i_charge_start(start), .i_input_power(pwr),
    .i_input_present(pres), .i_iin_over_pin(iin_p),
    .i_vin_droop_pin(droop_p), .i_vin_below_1v_pin(low_p),
    .o_charge_current_code(code), .o_thermal_reg_active(therm),
    .o_charge_suspend(susp), .o_bsr_start(bsr), .o_telemetry_on(tel_on),
    .o_telemetry_tick(tick), .o_input_current_cap_code(cap),
    .o_iin_limit_active(iin_a), .o_uv_code_active(uv),
    .o_uv_limit_active(uv_a), .o_storage_armed(armed),
    .o_storage_enter(enter));
  ccrb_host_model ccrb_host_model_inst (.i_clk, .i_rd_valid(rdv),
    .i_rd_data(rdd), .o_cmd(cmd), .o_wr(wr), .o_wdata(wd), .o_rd(rd));

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic gap(output int n);
    n = 0;
    while (tick !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (tick !== 1'b1 && n < 300);
  endtask

  // ========================================
  // Scenarios
  task automatic t_reset();
    logic [7:0]  c[7] = '{8'h10, 8'h11, 8'h14, 8'h15, 8'h16, 8'h19, 8'h12};
    logic [15:0] e[7] = '{16'h45e9, 16'h46d2, 16'h0, 16'h3f, 16'h1f, 16'h0,
                          16'h0};
    foreach (c[i]) begin
      ccrb_host_model_inst.rd(c[i], q);
      chk("reset word", q, e[i]);
    end
    $display("done reset values");
  endtask
  task automatic t_fields();
    ccrb_host_model_inst.wr(CMD_SYS_CFG, 16'hffff);
    ccrb_host_model_inst.rd(CMD_SYS_CFG, q);
    chk("config", q, 16'h003e);
    chk("halt", {susp, 10'h0, code}, 16'h8000);
    ccrb_host_model_inst.wr(CMD_SYS_CFG, 16'h0000);
    ccrb_host_model_inst.wr(CMD_IIN_CAP, 16'hffc0);
    ccrb_host_model_inst.rd(CMD_IIN_CAP, q);
    chk("cap", {q[15:6], cap}, 16'h0);
    ccrb_host_model_inst.wr(CMD_UV_CODE, 16'h1234);
    ccrb_host_model_inst.rd(CMD_UV_CODE, q);
    chk("droop", {q[15:8], uv}, 16'h0034);
    $display("done field widths");
  endtask
  task automatic t_charge();
    set = 5'h1f;
    temp = 16'h464d;
    cyc(3);
    chk("slope", {therm, code}, 16'h0031);
    temp = 16'h4800;
    cyc(3);
    chk("hot", {therm, code}, 16'h0020);
    temp = 16'h0000;
    algo = 1'b1;
    cyc(3);
    chk("algo", {therm, code}, 16'h0003);
    algo = 1'b0;
    iin_p = 1'b1;
    cyc(7);
    chk("iin", {iin_a, code}, 16'h0020);
    iin_p = 1'b0;
    cyc(7);
    chk("free", {iin_a, code}, 16'h001f);
    droop_p = 1'b1;
    cyc(7);
    chk("droop cut", {uv_a, code}, 16'h0020);
    droop_p = 1'b0;
    cyc(7);
    $display("done charge code");
  endtask
  task automatic t_bsr();
    int k;
    k = 0;
    ccrb_host_model_inst.wr(CMD_SYS_CFG, 16'h0010);
    repeat (10) begin
      k += bsr;
      cyc(1);
    end
    chk("bsr idle", k[15:0], 16'd0);
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    repeat (10) begin
      k += bsr;
      cyc(1);
    end
    chk("bsr at start", k[15:0], 16'd1);
    run = 1'b1;
    ccrb_host_model_inst.wr(CMD_SYS_CFG, 16'h0000);
    ccrb_host_model_inst.wr(CMD_SYS_CFG, 16'h0010);
    repeat (10) begin
      k += bsr;
      cyc(1);
    end
    chk("bsr pulses", k[15:0], 16'd2);
    run = 1'b0;
    ccrb_host_model_inst.wr(CMD_SYS_CFG, 16'h0000);
    $display("done measurement start");
  endtask
  task automatic t_tel();
    int n;
    chk("tel off", {15'h0, tel_on}, 16'h0);
    ccrb_host_model_inst.wr(CMD_SYS_CFG, 16'h000c);
    gap(n);
    chk("fast gap", n[15:0], 16'd20);
    ccrb_host_model_inst.wr(CMD_SYS_CFG, 16'h0004);
    gap(n);
    chk("slow gap", n[15:0], 16'd100);
    $display("done telemetry");
  endtask
  task automatic t_mppt();
    int n;
    ccrb_host_model_inst.wr(CMD_SYS_CFG, 16'h000a);
    ccrb_host_model_inst.wr(CMD_UV_CODE, 16'h0050);
    ccrb_host_model_inst.rd(CMD_UV_ACTIVE, q);
    chk("track start", q, 16'h0034);
    pres = 1'b1;
    gap(n);
    cyc(1);
    chk("track up", {8'h00, uv}, 16'h0036);
    pwr = 16'h0080;
    gap(n);
    cyc(1);
    chk("track back", {8'h00, uv}, 16'h0034);
    pres = 1'b0;
    ccrb_host_model_inst.wr(CMD_SYS_CFG, 16'h0000);
    chk("written back", {8'h00, uv}, 16'h0050);
    $display("done power tracking");
  endtask
  task automatic t_ship();
    ccrb_host_model_inst.wr(CMD_STORE_KEY, 16'h534d);
    ccrb_host_model_inst.wr(CMD_STORE_KEY, 16'h534c);
    chk("near key", {armed, enter}, 16'h0);
    ccrb_host_model_inst.wr(CMD_STORE_KEY, 16'h534d);
    cyc(8);
    chk("armed", {armed, enter}, 16'h2);
    low_p = 1'b1;
    cyc(8);
    chk("entered", {armed, enter}, 16'h3);
    i_sys_rst = 1'b1;
    cyc(2);
    i_sys_rst = 1'b0;
    chk("after reset", {armed, enter}, 16'h0);
    ccrb_host_model_inst.wr(CMD_STORE_KEY, 16'h534d);
    cyc(4);
    chk("at once", {armed, enter}, 16'h3);
    $display("done storage mode");
  endtask

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    {run, start, pres, algo, iin_p, droop_p, low_p} = '0;
    {temp, set, acode} = {16'h0000, 5'h0a, 5'h03};
    pwr = 16'h0100;
    {err_total, n_compared, cycles} = '0;
    i_sys_rst = 1'b1;
    cyc(3);
    i_sys_rst = 1'b0;
    t_reset();
    t_fields();
    t_charge();
    t_bsr();
    t_tel();
    t_mppt();
    t_ship();
    stop_test();
  end
endmodule

bind ccrb_top ccrb_properties ccrb_properties_inst (.i_clk, .i_sys_rst,
  .i_cmd_code, .i_wr_word, .i_wr_data, .i_rd_word, .o_rd_valid, .o_rd_data,
  .o_charge_current_code, .o_charge_suspend, .o_bsr_start,
  .o_input_current_cap_code, .o_iin_limit_active, .o_uv_limit_active,
  .o_storage_armed,
  .o_storage_enter);
